// ===== hw/serial_word_receiver.sv
/*
  Three-wire serial word receiver: shift clock, data and word strobe, LSB first.
  Assumes the pins are synchronous to clk and much slower than it.
*/
`timescale 1ns/1ns
module serial_word_receiver (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        accept,
  input  wire logic        shiftClk,
  input  wire logic        serialDataIn,
  input  wire logic        wordStrobe,
  output logic             wordValid,
  output logic [15:0]      wordData,
  output logic             strobeFall
);
  import stepper_cmd_pkg::*;

  typedef struct packed {
    logic        sclkPrev;
    logic        strobePrev;
    logic [15:0] shift;
    logic [3:0]  bitCnt;
    logic        wordValid;
    logic [15:0] wordData;
    logic        strobeFall;
  } rx_state_t;

  rx_state_t st_r;
  rx_state_t st_nxt;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.wordValid  = 1'b0;
    st_nxt.strobeFall = 1'b0;
    st_nxt.sclkPrev   = shiftClk;
    st_nxt.strobePrev = wordStrobe;
    if (accept && wordStrobe && shiftClk && !st_r.sclkPrev) begin
      st_nxt.shift  = {serialDataIn, st_r.shift[15:1]};
      st_nxt.bitCnt = st_r.bitCnt + 4'h1;
      if (st_r.bitCnt == 4'hf) begin
        st_nxt.wordValid = 1'b1;
        st_nxt.wordData  = {serialDataIn, st_r.shift[15:1]};
      end
    end
    if (st_r.strobePrev && !wordStrobe) begin
      st_nxt.strobeFall = 1'b1;
      st_nxt.bitCnt     = 4'h0;
    end
    if (!accept) begin
      st_nxt.bitCnt = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wordValid  = st_r.wordValid;
  assign wordData   = st_r.wordData;
  assign strobeFall = st_r.strobeFall;

  blocked_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
    !accept |=> !st_r.wordValid) else $error("word taken while input blocked");

  word_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.strobeFall |-> (st_r.bitCnt == 4'h0)) else $error("partial bits kept past strobe fall");

endmodule // serial_word_receiver

// ===== hw/stepper_cmd_pkg.sv
/*
  Constants, field layout and phase encoding for the stepper serial command and stop logic.
  Assumes a single 100 MHz system clock; all pins are sampled as synchronous inputs.
*/
package stepper_cmd_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int WORD_BITS     = 16;
  localparam int ADDR_LSB      = 13;
  localparam int PAYLOAD_BITS  = 13;
  localparam int NUM_WORDS     = 6;

  // Configuration word addresses.
  localparam logic [2:0] ADDR_START_WAIT = 3'h0;
  localparam logic [2:0] ADDR_CHOP       = 3'h1;
  localparam logic [2:0] ADDR_DRIVE      = 3'h2;
  localparam logic [2:0] ADDR_RAMP_MULT  = 3'h3;
  localparam logic [2:0] ADDR_PERIOD     = 3'h4;
  localparam logic [2:0] ADDR_COUNT      = 3'h5;
  localparam logic [2:0] ADDR_LAST       = 3'h5;

  // Field positions inside the payloads.
  localparam int START_WAIT_LSB = 0;
  localparam int EXC_WAIT_LSB   = 6;
  localparam int CHOP_LSB       = 0;
  localparam int CURRENT_LSB    = 0;
  localparam int DIR_BIT        = 5;
  localparam int STOP_BIT       = 6;
  localparam int OUT_EN_BIT     = 7;
  localparam int MODE_BIT       = 8;
  localparam int TWO_CUR_BIT    = 9;
  localparam int FLAG_ONCE_BIT  = 10;
  localparam int FLAG_70_BIT    = 11;
  localparam int MULT_LSB       = 0;

  // Excitation positions on the 64-step cycle; index 0 is ch1 +100 %, ch2 0 %.
  localparam logic [5:0] POS_RESET      = 6'h00;
  localparam logic [5:0] POS_TWO_PHASE  = 6'h08;
  localparam logic [3:0] QUARTER_ONE    = 4'h0;
  localparam logic [3:0] QUARTER_TWO    = 4'h8;
  localparam logic [5:0] MICRO_STEP     = 6'h01;
  localparam logic [5:0] TWO_PHASE_STEP = 6'h10;

  // Oscillator edges per wait-time unit and the shortest step period.
  localparam logic [3:0]  OSC_TICKS_PER_UNIT = 4'h8;
  localparam logic [12:0] MIN_PERIOD         = 13'h0001;

  typedef enum logic [2:0] {
    PH_IDLE       = 3'b000,
    PH_START_WAIT = 3'b001,
    PH_EXC_WAIT   = 3'b011,
    PH_RUN        = 3'b010,
    PH_HOLD       = 3'b110
  } phase_t;

endpackage

// ===== hw/stepper_serial_command_stop_logic.sv
/*
  Command, phase-position flag and stop-mode logic of a two-channel stepper microstep driver.
  Assumes all pins are synchronous to clk; the oscillator pin is sampled and its rising edges time the stepping.
*/
`timescale 1ns/1ns
module stepper_serial_command_stop_logic (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        shiftClk,
  input  wire logic        serialDataIn,
  input  wire logic        wordStrobe,
  input  wire logic        resetInN,
  input  wire logic        outputEnable,
  input  wire logic        oscillatorClockIn,
  output logic             phasePositionFlagOut,
  output logic             phasePositionFlagOe,
  output logic             motorOutEnable,
  output logic             stepPulse,
  output logic [5:0]       excitationIndex,
  output logic             twoPhaseMode,
  output logic             twoPhaseCurrentSel,
  output logic [4:0]       motorCurrent,
  output logic [5:0]       chopFrequency,
  output stepper_cmd_pkg::phase_t drivePhase
);
  import stepper_cmd_pkg::*;

  typedef struct packed {
    logic [5:0][12:0] cfg;
    logic [5:0][12:0] pend;
    logic [5:0]       pendValid;
    phase_t           phase;
    logic [5:0]       waitCnt;
    logic [12:0]      periodCnt;
    logic [15:0]      pulsesLeft;
    logic [5:0]       pos;
    logic             oscPrev;
    logic [3:0]       unitCnt;
    logic             energized;
    logic             stepPulse;
    logic             flagOut;
    logic             flagOe;
    logic             motorOn;
  } drv_state_t;

  drv_state_t st_r;
  drv_state_t st_nxt;

  logic        accept;
  logic        wordValid;
  logic [15:0] wordData;
  logic        strobeFall;
  logic        oscTick;
  logic        unitTick;
  logic        stopMode;
  logic        twoPhase;
  logic [2:0]  wordAddr;
  logic [15:0] pulsesTotal;
  logic [12:0] periodLoad;
  logic [5:0]  stepSize;
  logic        inWait;

  function automatic logic flagLow(input logic [5:0] p, input logic tp, input logic sel70,
                                   input logic once);
    logic [3:0] q;
    q = sel70 ? QUARTER_TWO : QUARTER_ONE;
    if (tp) begin
      return p == POS_TWO_PHASE;
    end else if (once) begin
      return p == {2'b00, q};
    end
    return p[3:0] == q;
  endfunction

  // Inputs are dropped in the wait phases and whenever the driver is held off.
  assign inWait = (st_r.phase == PH_START_WAIT) || (st_r.phase == PH_EXC_WAIT);
  assign accept = resetInN && outputEnable && !inWait;

  serial_word_receiver serial_word_receiver_inst (
    .clk          (clk),
    .rst_n        (rst_n),
    .accept       (accept),
    .shiftClk     (shiftClk),
    .serialDataIn (serialDataIn),
    .wordStrobe   (wordStrobe),
    .wordValid    (wordValid),
    .wordData     (wordData),
    .strobeFall   (strobeFall)
  );

  assign oscTick  = oscillatorClockIn && !st_r.oscPrev;
  assign unitTick = oscTick && (st_r.unitCnt == OSC_TICKS_PER_UNIT - 4'h1);
  assign wordAddr = wordData[15:ADDR_LSB];
  assign stopMode = st_r.cfg[ADDR_DRIVE][STOP_BIT];
  assign twoPhase = st_r.cfg[ADDR_DRIVE][MODE_BIT];
  assign stepSize = twoPhase ? TWO_PHASE_STEP : MICRO_STEP;
  assign pulsesTotal = 16'(st_r.cfg[ADDR_COUNT]) << st_r.cfg[ADDR_RAMP_MULT][MULT_LSB +: 2];
  assign periodLoad  = (st_r.cfg[ADDR_PERIOD] == 13'h0000) ? MIN_PERIOD : st_r.cfg[ADDR_PERIOD];

  always_comb begin
    st_nxt           = st_r;
    st_nxt.stepPulse = 1'b0;
    st_nxt.oscPrev   = oscillatorClockIn;
    if (oscTick) begin
      st_nxt.unitCnt = unitTick ? 4'h0 : st_r.unitCnt + 4'h1;
    end

    if (wordValid && accept) begin
      if (wordAddr <= ADDR_LAST) begin
        st_nxt.pend[wordAddr]      = wordData[PAYLOAD_BITS-1:0];
        st_nxt.pendValid[wordAddr] = 1'b1;
      end
    end

    if (strobeFall) begin
      for (int a = 0; a < NUM_WORDS; a++) begin
        if (st_nxt.pendValid[a]) begin
          st_nxt.cfg[a] = st_nxt.pend[a];
        end
      end
      st_nxt.pendValid = '0;
    end

    case (st_r.phase)
      PH_IDLE, PH_HOLD: begin
        // A committed step count launches a new move.
        if (strobeFall && st_nxt.pendValid == '0 && st_r.pendValid[ADDR_COUNT]) begin
          st_nxt.phase   = PH_START_WAIT;
          st_nxt.waitCnt = st_r.cfg[ADDR_START_WAIT][START_WAIT_LSB +: 6];
          st_nxt.unitCnt = 4'h0;
        end else if (st_r.phase == PH_HOLD && !stopMode) begin
          st_nxt.phase = PH_IDLE;
        end
      end
      PH_START_WAIT: begin
        if (st_r.waitCnt == 6'h00) begin
          st_nxt.phase     = PH_EXC_WAIT;
          st_nxt.energized = 1'b1;
          st_nxt.waitCnt   = st_r.cfg[ADDR_START_WAIT][EXC_WAIT_LSB +: 6];
        end else if (unitTick) begin
          st_nxt.waitCnt = st_r.waitCnt - 6'h01;
        end
      end
      PH_EXC_WAIT: begin
        if (st_r.waitCnt == 6'h00) begin
          st_nxt.phase      = PH_RUN;
          st_nxt.periodCnt  = periodLoad;
          st_nxt.pulsesLeft = pulsesTotal;
        end else if (unitTick) begin
          st_nxt.waitCnt = st_r.waitCnt - 6'h01;
        end
      end
      PH_RUN: begin
        if (stopMode ? !st_r.flagOut : (st_r.pulsesLeft == 16'h0000)) begin
          st_nxt.phase = stopMode ? PH_HOLD : PH_IDLE;
        end else if (oscTick && outputEnable) begin
          // steps need oscillator.
          // Standby blocks the step; only the two-phase snap and the reset input move the position without a pulse.
          if (st_r.periodCnt <= MIN_PERIOD) begin
            st_nxt.stepPulse = 1'b1;
            st_nxt.periodCnt = periodLoad;
            st_nxt.pos       = st_r.cfg[ADDR_DRIVE][DIR_BIT] ? st_r.pos - stepSize : st_r.pos + stepSize;
            if (!stopMode) begin
              st_nxt.pulsesLeft = st_r.pulsesLeft - 16'h0001;
            end
          end else begin
            st_nxt.periodCnt = st_r.periodCnt - 13'h0001;
          end
        end
      end
      default: begin
        st_nxt.phase = PH_IDLE;
      end
    endcase

    // Two-phase drive sits on the diagonal positions only.
    if (st_nxt.cfg[ADDR_DRIVE][MODE_BIT] && st_nxt.pos[3:0] != QUARTER_TWO) begin
      st_nxt.pos = {st_nxt.pos[5:4], QUARTER_TWO};
    end

    if (!outputEnable) begin
      st_nxt.phase     = PH_IDLE;
      st_nxt.stepPulse = 1'b0;
    end

    st_nxt.flagOut = !flagLow(st_nxt.pos, st_nxt.cfg[ADDR_DRIVE][MODE_BIT],
                              st_nxt.cfg[ADDR_DRIVE][FLAG_70_BIT], st_nxt.cfg[ADDR_DRIVE][FLAG_ONCE_BIT]);
    st_nxt.flagOe  = resetInN && outputEnable;
    st_nxt.motorOn = resetInN && outputEnable && st_nxt.energized && st_nxt.cfg[ADDR_DRIVE][OUT_EN_BIT];

    if (!resetInN) begin
      st_nxt         = '0;
      st_nxt.pos     = POS_RESET;
      st_nxt.flagOut = 1'b0;
      // The edge detector keeps tracking the pin, so no false tick follows the clear.
      st_nxt.oscPrev = oscillatorClockIn;
    end
  end

  // Holding reset in one register image keeps every output a plain flop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phasePositionFlagOut = st_r.flagOut;
  assign phasePositionFlagOe  = st_r.flagOe;
  assign motorOutEnable       = st_r.motorOn;
  assign stepPulse            = st_r.stepPulse;
  assign excitationIndex      = st_r.pos;
  assign twoPhaseMode         = st_r.cfg[ADDR_DRIVE][MODE_BIT];
  assign twoPhaseCurrentSel   = st_r.cfg[ADDR_DRIVE][TWO_CUR_BIT];
  assign motorCurrent         = st_r.cfg[ADDR_DRIVE][CURRENT_LSB +: 5];
  assign chopFrequency        = st_r.cfg[ADDR_CHOP][CHOP_LSB +: 6];
  assign drivePhase           = st_r.phase;

  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && !strobeFall) |=> (st_r.cfg == $past(st_r.cfg))) else $error("configuration moved without commit");

  unmapped_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && wordValid && wordAddr > ADDR_LAST && !strobeFall) |=> (st_r.pendValid == $past(st_r.pendValid)))
    else $error("unmapped word was stored");

  wait_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && inWait && !strobeFall) |=> (st_r.pendValid == $past(st_r.pendValid)))
    else $error("word stored during wait phase");

  flag_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!resetInN || !outputEnable) |=> (!st_r.flagOe && !st_r.motorOn)) else $error("flag driven while held off");

  reset_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !resetInN |=> (st_r.cfg == '0 && st_r.pos == POS_RESET && st_r.phase == PH_IDLE))
    else $error("reset input did not clear state");

  step_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.stepPulse |-> ($past(oscillatorClockIn) && !$past(st_r.oscPrev))) else $error("step without oscillator edge");

  stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.phase == PH_RUN && stopMode && !st_r.flagOut && resetInN && outputEnable)
    |=> (st_r.phase == PH_HOLD && !st_r.stepPulse) ##1 !st_r.stepPulse) else $error("stop mode kept stepping");

  step_moves_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.stepPulse && $past(resetInN)) |-> (st_r.pos != $past(st_r.pos))) else $error("step pulse without motion");

  commit_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && strobeFall && !wordValid && st_r.pendValid[ADDR_DRIVE])
    |=> (st_r.cfg[ADDR_DRIVE] == $past(st_r.pend[ADDR_DRIVE]))) else $error("pending word not applied at commit");

  pend_last_a: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && wordValid && !strobeFall && wordAddr == ADDR_DRIVE)
    |=> (st_r.pendValid[ADDR_DRIVE] && st_r.pend[ADDR_DRIVE] == $past(wordData[PAYLOAD_BITS-1:0])))
    else $error("latest word did not replace pending word");

  flag_micro_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_r.cfg[ADDR_DRIVE][MODE_BIT] && !st_r.cfg[ADDR_DRIVE][FLAG_70_BIT] && !st_r.cfg[ADDR_DRIVE][FLAG_ONCE_BIT])
    |-> (st_r.flagOut == (st_r.pos[3:0] != QUARTER_ONE))) else $error("microstep flag off its position");

  flag_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.cfg[ADDR_DRIVE][MODE_BIT] |-> (st_r.flagOut == (st_r.pos != POS_TWO_PHASE)))
    else $error("two-phase flag off its position");

  standby_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && !outputEnable && !strobeFall)
    |=> (st_r.phase == PH_IDLE && !st_r.stepPulse && st_r.pos == $past(st_r.pos))) else $error("standby moved the drive");

  osc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && !oscTick && !strobeFall) |=> (!st_r.stepPulse && st_r.pos == $past(st_r.pos)))
    else $error("drive moved without oscillator edge");

  hold_resume_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetInN && outputEnable && st_r.phase == PH_HOLD && !stopMode && !strobeFall) |=> (st_r.phase == PH_IDLE))
    else $error("stop hold not left after release");

endmodule // stepper_serial_command_stop_logic

// ===== verification/host_serial_model.sv
/*
  Host-side model of the three-wire command link: shift clock, data and word strobe.
  Assumes a free-running clk and is driven through its tasks by the testbench.
*/
`timescale 1ns/1ns
module host_serial_model (
  input  wire logic clk,
  output logic      shiftClk,
  output logic      serialDataIn,
  output logic      wordStrobe
);
  initial begin
    shiftClk     = 1'b0;
    serialDataIn = 1'b0;
    wordStrobe   = 1'b0;
  end

  // Every shift-clock, strobe and data-bit level is held at least two clk cycles, as the receiver samples them.
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_strobe(input logic v);
    hold(2);
    wordStrobe = v;
    hold(2);
  endtask

  task automatic shift_bits(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      serialDataIn = w[i];
      hold(2);
      shiftClk = 1'b1;
      hold(2);
      shiftClk = 1'b0;
    end
    // The released data line is inverted so a stale level never passes for a bit.
    serialDataIn = ~serialDataIn;
  endtask
endmodule // host_serial_model

// ===== verification/stepper_serial_command_stop_logic_test.sv
/*
  Self-checking testbench of the stepper command, flag and stop-mode logic.
  Assumes the host model drives the serial link and the bench drives the other pins.
*/
`timescale 1ns/1ns
module stepper_serial_command_stop_logic_test;
  import stepper_cmd_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       resetInN = 1'b1;
  logic       outputEnable = 1'b1;
  logic       oscillatorClockIn = 1'b0;
  logic       oscRun = 1'b0;
  logic       shiftClk, serialDataIn, wordStrobe;
  logic       flagOut, flagOe, motorOutEnable, stepPulse, twoPhaseMode, twoPhaseCurrentSel;
  logic [5:0] excitationIndex, chopFrequency;
  logic [4:0] motorCurrent;
  phase_t     drivePhase;
  int         badCount = 0;
  int         samplesChecked = 0;
  int         stepCnt = 0;

  always #5 clk = ~clk;

  // the oscillator runs only when the bench lets it.
  always begin
    repeat (10) @(posedge clk);
    #1;
    if (oscRun) oscillatorClockIn = ~oscillatorClockIn;
  end

  always @(posedge clk) if (stepPulse === 1'b1) stepCnt++;

  host_serial_model host_serial_model_inst (.clk(clk), .shiftClk(shiftClk), .serialDataIn(serialDataIn),
    .wordStrobe(wordStrobe));

  stepper_serial_command_stop_logic stepper_serial_command_stop_logic_inst (
    .clk(clk), .rst_n(rst_n), .shiftClk(shiftClk), .serialDataIn(serialDataIn), .wordStrobe(wordStrobe),
    .resetInN(resetInN), .outputEnable(outputEnable), .oscillatorClockIn(oscillatorClockIn),
    .phasePositionFlagOut(flagOut), .phasePositionFlagOe(flagOe), .motorOutEnable(motorOutEnable),
    .stepPulse(stepPulse), .excitationIndex(excitationIndex), .twoPhaseMode(twoPhaseMode),
    .twoPhaseCurrentSel(twoPhaseCurrentSel), .motorCurrent(motorCurrent), .chopFrequency(chopFrequency),
    .drivePhase(drivePhase));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic hold(input int n);
    host_serial_model_inst.hold(n);
  endtask

  // Sends the first n words in one strobe-high interval, then waits for the commit.
  task automatic wr(input int n, input logic [15:0] w0, w1 = 16'h0000, w2 = 16'h0000, w3 = 16'h0000);
    host_serial_model_inst.set_strobe(1'b1);
    if (n > 0) host_serial_model_inst.shift_bits(w0, 16);
    if (n > 1) host_serial_model_inst.shift_bits(w1, 16);
    if (n > 2) host_serial_model_inst.shift_bits(w2, 16);
    if (n > 3) host_serial_model_inst.shift_bits(w3, 16);
    host_serial_model_inst.set_strobe(1'b0);
    hold(4);
  endtask

  task automatic wait_phase(input phase_t p);
    int n;
    n = 0;
    while (drivePhase !== p && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("drivePhase", 16'(p), 16'(drivePhase));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    badCount++;
    tally_and_finish();
  end

  initial begin
    hold(3);
    rst_n = 1'b1;
    hold(3);
    check("drivePhase", 16'(PH_IDLE), 16'(drivePhase));
    check("excitationIndex", 16'(POS_RESET), 16'(excitationIndex));
    check("flagOut", 16'h0000, 16'(flagOut));
    wr(1, 16'h0000);
    $display("reset test done");

    wr(3, {ADDR_DRIVE, 13'h0015}, {ADDR_CHOP, 13'h002A}, {ADDR_DRIVE, 13'h0013});
    host_serial_model_inst.set_strobe(1'b1);
    host_serial_model_inst.shift_bits({ADDR_CHOP, 13'h001F}, 5);
    host_serial_model_inst.set_strobe(1'b0);
    hold(4);
    check("motorCurrent", 16'h0013, 16'(motorCurrent));
    check("chopFrequency", 16'h002A, 16'(chopFrequency));
    $display("word test done");

    wr(2, {3'h6, 13'h1FFF}, {3'h7, 13'h1FFF});
    wr(0, 16'h0000);
    host_serial_model_inst.shift_bits({ADDR_DRIVE, 13'h0004}, 16);
    wr(0, 16'h0000);
    check("motorCurrent", 16'h0013, 16'(motorCurrent));
    check("chopFrequency", 16'h002A, 16'(chopFrequency));
    $display("ignore test done");

    wr(4, {ADDR_START_WAIT, 13'h0001}, {ADDR_PERIOD, 13'h0001}, {ADDR_RAMP_MULT, 13'h0000},
       {ADDR_DRIVE, 13'h0093});
    wr(1, {ADDR_COUNT, 13'h0003});
    hold(20);
    check("drivePhase", 16'(PH_START_WAIT), 16'(drivePhase));
    check("stepCnt", 16'h0000, 16'(stepCnt));
    wr(1, {ADDR_CHOP, 13'h0005});
    check("chopFrequency", 16'h002A, 16'(chopFrequency));
    oscRun = 1'b1;
    wait_phase(PH_RUN);
    check("motorOutEnable", 16'h0001, 16'(motorOutEnable));
    wait_phase(PH_IDLE);
    check("stepCnt", 16'h0003, 16'(stepCnt));
    check("excitationIndex", 16'h0003, 16'(excitationIndex));
    $display("move test done");

    wr(2, {ADDR_DRIVE, 13'h0053}, {ADDR_COUNT, 13'h0001});
    wait_phase(PH_HOLD);
    check("stepCnt", 16'h0010, 16'(stepCnt));
    check("excitationIndex", 16'h0010, 16'(excitationIndex));
    check("flagOut", 16'h0000, 16'(flagOut));
    check("motorOutEnable", 16'h0000, 16'(motorOutEnable));
    wr(1, {ADDR_DRIVE, 13'h0893});
    wait_phase(PH_IDLE);
    check("flagOut", 16'h0001, 16'(flagOut));
    $display("stop test done");

    outputEnable = 1'b0;
    hold(3);
    check("flagOe", 16'h0000, 16'(flagOe));
    check("motorOutEnable", 16'h0000, 16'(motorOutEnable));
    wr(1, {ADDR_DRIVE, 13'h0007});
    outputEnable = 1'b1;
    hold(3);
    check("motorCurrent", 16'h0013, 16'(motorCurrent));
    check("excitationIndex", 16'h0010, 16'(excitationIndex));
    check("flagOe", 16'h0001, 16'(flagOe));
    check("motorOutEnable", 16'h0001, 16'(motorOutEnable));
    resetInN = 1'b0;
    hold(3);
    check("flagOe", 16'h0000, 16'(flagOe));
    check("motorCurrent", 16'h0000, 16'(motorCurrent));
    check("chopFrequency", 16'h0000, 16'(chopFrequency));
    check("excitationIndex", 16'h0000, 16'(excitationIndex));
    resetInN = 1'b1;
    hold(3);
    $display("standby test done");

    wr(1, {ADDR_DRIVE, 13'h0300});
    check("twoPhaseMode", 16'h0001, 16'(twoPhaseMode));
    check("twoPhaseCurrentSel", 16'h0001, 16'(twoPhaseCurrentSel));
    check("excitationIndex", 16'h0008, 16'(excitationIndex));
    check("flagOut", 16'h0000, 16'(flagOut));
    wr(2, {ADDR_DRIVE, 13'h0320}, {ADDR_COUNT, 13'h0001});
    hold(40);
    check("stepCnt", 16'h0011, 16'(stepCnt));
    check("excitationIndex", 16'h0038, 16'(excitationIndex));
    check("flagOut", 16'h0001, 16'(flagOut));
    check("drivePhase", 16'(PH_IDLE), 16'(drivePhase));
    $display("two-phase test done");
    tally_and_finish();
  end
endmodule // stepper_serial_command_stop_logic_test
